// ==== core/octal_switch_pkg.sv ====
// Purpose: shared constants and types for the octal switch serial control
// Assumes: 100 MHz system clock; serial clock sampled as a plain input
// Notes: channel eight sits at bit 7, channel one at bit 0
package octal_switch_pkg;
  localparam int NUM_CH = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FAULT_FILTER_US = 300;
  localparam int FAULT_FILTER_CYC = (FAULT_FILTER_US * 1000) / CLK_PERIOD_NS;
  localparam logic [NUM_CH-1:0] CMD_RESET = 8'h00;
  localparam logic [NUM_CH-1:0] FAULT_RESET = 8'h00;

  typedef logic [NUM_CH-1:0] chan_t;

  // Per-channel analog conditions reported by the output stages
  typedef struct packed {
    chan_t short_supply;
    chan_t short_ground;
    chan_t open_load;
    chan_t thermal_limit;
  } chan_cond_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEL = 3'b010,
    ST_COMMIT = 3'b100
  } link_state_e;
endpackage

// ==== core/sync2.sv ====
// Purpose: two-flop synchroniser for a vector of asynchronous levels
// Assumes: inputs come from pins outside the clk_i domain
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;
endmodule

// ==== core/octal_switch_serial_control.sv ====
// Purpose: serial command/fault logic of an eight-channel power switch
// Assumes: link pins sampled by clk_i; rst_i stands for logic-supply reset
// Notes: fault filter length is a parameter so benches can shorten it
`timescale 1ns/10ps
module octal_switch_serial_control
  import octal_switch_pkg::*;
#(
  parameter int NCH = NUM_CH,
  parameter int FILTER_CYC = FAULT_FILTER_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial link pins
  input wire logic select_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_n_o,
  // Device control
  input wire logic enable_i,
  input wire logic load_supply_ovp_i,
  input wire chan_cond_s cond_i,
  // Channel drive and visibility
  output logic [NCH-1:0] drive_o,
  output logic [NCH-1:0] command_o,
  output logic [NCH-1:0] fault_status_o
);
  localparam int FCW = $clog2(FILTER_CYC + 1);
  localparam logic [FCW-1:0] FILTER_END = FCW'(FILTER_CYC);
  localparam int NSYNC = 5;

  // Synchronised pins
  logic [NSYNC-1:0] pins_s;
  logic cs_n_s;
  logic sck_s;
  logic din_s;
  logic en_s;
  logic ovp_s;

  sync2 #(
    .WIDTH(NSYNC)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    // Select crosses inverted so a reset sync reads as deselected, no false edge
    .d_i({~select_n_i, serial_clk_i, serial_in_i, enable_i, load_supply_ovp_i}),
    .q_o(pins_s)
  );

  assign cs_n_s = ~pins_s[4];
  assign sck_s = pins_s[3];
  assign din_s = pins_s[2];
  assign en_s = pins_s[1];
  assign ovp_s = pins_s[0];

  // Per-channel conditions cross separately; they may change any time
  chan_cond_s cond_s;

  sync2 #(
    .WIDTH($bits(chan_cond_s))
  ) u_cond_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(cond_i),
    .q_o(cond_s)
  );

  // Edge detection on synchronised levels
  logic cs_n_d_r;
  logic sck_d_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_n_d_r <= 1'b1;
      sck_d_r <= 1'b0;
    end else begin
      cs_n_d_r <= cs_n_s;
      sck_d_r <= sck_s;
    end
  end

  wire cs_fall = cs_n_d_r & ~cs_n_s;
  wire cs_rise = ~cs_n_d_r & cs_n_s;
  wire selected = ~cs_n_s & ~cs_n_d_r;
  wire sck_fall = selected & sck_d_r & ~sck_s;
  wire sck_rise = selected & ~sck_d_r & sck_s;

  // Link state
  link_state_e state_r;
  link_state_e state_nxt;

  always_comb begin
    case (state_r)
      ST_IDLE: state_nxt = cs_fall ? ST_SEL : ST_IDLE;
      ST_SEL: state_nxt = cs_rise ? ST_COMMIT : ST_SEL;
      ST_COMMIT: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Shift register and output bit
  logic [NCH-1:0] shift_r;
  logic [NCH-1:0] shift_nxt;
  logic out_bit_r;
  logic out_bit_nxt;
  logic [NCH-1:0] fault_r;

  wire [NCH-1:0] shift_in = {shift_r[NCH-2:0], din_s};

  // Fault snapshot at select fall; last bit moves out on rising clock
  assign shift_nxt = cs_fall ? fault_r :
                     sck_fall ? shift_in : shift_r;
  assign out_bit_nxt = cs_fall ? 1'b0 :
                       sck_rise ? shift_r[NCH-1] : out_bit_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_r <= FAULT_RESET;
      out_bit_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      out_bit_r <= out_bit_nxt;
    end
  end

  // Output driven only while selected; enable active low
  assign serial_out_o = out_bit_r;
  assign serial_out_oe_n_o = cs_n_s;

  // Command latch
  logic [NCH-1:0] cmd_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_r <= CMD_RESET;
    end else if (state_r == ST_COMMIT) begin
      cmd_r <= shift_r;
    end
  end

  // Filter restarts at each commit so switching transients are masked
  logic [FCW-1:0] filt_cnt_r [NCH];
  logic [NCH-1:0] raw_fault;
  logic [NCH-1:0] filt_done;
  logic [NCH-1:0] open_latch_r;
  logic [NCH-1:0] live_fault;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // Open load counts only when commanded off
      assign raw_fault[g] = en_s & (cond_s.short_supply[g] | cond_s.short_ground[g] |
                            cond_s.thermal_limit[g] |
                            (cond_s.open_load[g] & ~cmd_r[g]));
      assign filt_done[g] = (filt_cnt_r[g] == FILTER_END);

      always_ff @(posedge clk_i) begin
        if (rst_i || state_r == ST_COMMIT || !raw_fault[g]) begin
          filt_cnt_r[g] <= '0;
        end else if (!filt_done[g]) begin
          filt_cnt_r[g] <= filt_cnt_r[g] + FCW'(1);
        end
      end

      // Latched until the next snapshot; new event wins over clear
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          open_latch_r[g] <= 1'b0;
        end else if (en_s && filt_done[g] && cond_s.open_load[g] && !cmd_r[g]) begin
          open_latch_r[g] <= 1'b1;
        end else if (cs_fall) begin
          open_latch_r[g] <= 1'b0;
        end
      end

      assign live_fault[g] = filt_done[g] | (en_s & open_latch_r[g]);

      // Thermal shutdown local; over-voltage and enable global
      assign drive_o[g] = cmd_r[g] & en_s & ~ovp_s &
                          ~cond_s.thermal_limit[g];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_r <= FAULT_RESET;
    end else if (en_s) begin
      fault_r <= live_fault;
    end
  end

  assign command_o = cmd_r;
  assign fault_status_o = fault_r;
endmodule

// ==== verif/octal_switch_sva.sv ====
// Purpose: port checks for octal switch control
// Assumes: pins pass 2-flop syncs
// Notes: depths allow sync latency
`timescale 1ns/10ps
module octal_switch_sva
  import octal_switch_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic select_n_i,
  input wire logic enable_i,
  input wire logic load_supply_ovp_i,
  input wire chan_cond_s cond_i,
  input wire logic serial_out_oe_n_o,
  input wire logic [NCH-1:0] drive_o,
  input wire logic [NCH-1:0] command_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_off: assert property (disable iff (1'b0) rst_i |=> drive_o == '0)
    else $error("drive on in reset");
  a_oe_idle: assert property (select_n_i [*5] |-> serial_out_oe_n_o)
    else $error("out driven idle");
  a_oe_sel: assert property (!select_n_i [*6] |-> !serial_out_oe_n_o)
    else $error("out not driven");
  a_en_off: assert property (!enable_i [*4] |-> drive_o == '0)
    else $error("drive while disabled");
  a_ovp_off: assert property (load_supply_ovp_i [*4] |-> drive_o == '0)
    else $error("drive in overvoltage");
  a_hot_off: assert property ($stable(cond_i.thermal_limit) [*4] |->
    (drive_o & cond_i.thermal_limit) == '0)
    else $error("hot channel on");
  a_drive_cmd: assert property ((enable_i && !load_supply_ovp_i &&
    cond_i.thermal_limit == '0) [*4] |-> drive_o == command_o)
    else $error("drive differs");
  a_cmd_hold: assert property (!select_n_i [*8] |=> $stable(command_o))
    else $error("command moved");
endmodule

// ==== verif/spi_host_model.sv ====
// Purpose: host master model on the serial link
// Assumes: link clock 130 ns, 13 clk
// Notes: data line inverted once released
`timescale 1ns/10ps
module spi_host_model (
  // Clock
  input wire logic clk_i,
  // Link
  output logic select_n_o,
  output logic serial_clk_o,
  output logic serial_in_o,
  input wire logic serial_out_i
);
  initial begin
    select_n_o = 1'b1;
    serial_clk_o = 1'b0;
    serial_in_o = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Clock low at select edges
  task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
    rx = '0;
    select_n_o = 1'b0;
    cyc(10);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_o = tx[i];
      serial_clk_o = 1'b1;
      cyc(6);
      rx[i] = serial_out_i;
      serial_clk_o = 1'b0;
      cyc(7);
    end
    select_n_o = 1'b1;
    serial_in_o = ~serial_in_o;
    cyc(10);
  endtask
endmodule

// ==== verif/octal_switch_serial_control_tb_top.sv ====
// Purpose: bench for octal switch control
// Assumes: filter shortened to 20 clk
// Notes: host model drives the link
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module octal_switch_serial_control_tb_top;
  import octal_switch_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic enable_i = 1'b1;
  logic load_supply_ovp_i = 1'b0;
  chan_cond_s cond_i = '0;
  logic select_n_i, serial_clk_i, serial_in_i, serial_out_o, serial_out_oe_n_o;
  chan_t drive_o, command_o, fault_status_o;
  logic [15:0] rx;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  always #5 clk_i = ~clk_i;
  spi_host_model host (.clk_i, .select_n_o(select_n_i), .serial_clk_o(serial_clk_i),
    .serial_in_o(serial_in_i), .serial_out_i(serial_out_o));
  octal_switch_serial_control #(.FILTER_CYC(20)) DUT (.clk_i, .rst_i, .select_n_i,
    .serial_clk_i, .serial_in_i, .serial_out_o, .serial_out_oe_n_o, .enable_i,
    .load_supply_ovp_i, .cond_i, .drive_o, .command_o, .fault_status_o);
  task automatic close_out;
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out;
    end
  end
  initial begin
    wt(20);
    rst_i = 1'b0;
    wt(5);
    `CHK("oe_idle", 1'b1, serial_out_oe_n_o)
    host.xfer(8, 16'h00A5, rx);
    `CHK("rx0", 8'h00, rx[7:0])
    `CHK("cmd", 8'hA5, command_o)
    `CHK("drv", 8'hA5, drive_o)
    cond_i.thermal_limit = 8'h04;
    cond_i.open_load = 8'h01;
    cond_i.short_supply = 8'h40;
    wt(60);
    `CHK("drv_hot", 8'hA1, drive_o)
    host.xfer(8, 16'h005A, rx);
    `CHK("rx1", 8'h44, rx[7:0])
    wt(60);
    `CHK("flt", 8'h45, fault_status_o)
    cond_i.open_load = 8'h00;
    wt(10);
    host.xfer(8, 16'h0004, rx);
    `CHK("rx2", 8'h45, rx[7:0])
    cond_i = '0;
    wt(10);
    `CHK("drv_cool", 8'h04, drive_o)
    load_supply_ovp_i = 1'b1;
    wt(6);
    `CHK("drv_ovp", 8'h00, drive_o)
    load_supply_ovp_i = 1'b0;
    wt(6);
    `CHK("drv_back", 8'h04, drive_o)
    enable_i = 1'b0;
    wt(6);
    `CHK("drv_dis", 8'h00, drive_o)
    enable_i = 1'b1;
    wt(6);
    `CHK("drv_en", 8'h04, drive_o)
    host.xfer(16, 16'hC396, rx);
    `CHK("chain", 8'hC3, rx[7:0])
    `CHK("cmd16", 8'h96, command_o)
    close_out;
  end
endmodule
bind octal_switch_serial_control octal_switch_sva #(.NCH(NCH)) chk (.clk_i, .rst_i,
  .select_n_i, .enable_i, .load_supply_ovp_i, .cond_i, .serial_out_oe_n_o, .drive_o,
  .command_o);
